/* rco_top.sv */
// Reference clock output: APB control, sleep gating and the output pin.
// Assumes sleep_mode and osc_mode come from logic on ref_clk; the primary
// oscillator pin is asynchronous and is synchronised here.
`timescale 1ns/1ps
module rco_top (
  input logic ref_clk,
  input logic rst_b,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [7:0] paddr,
  input logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input logic sleep_mode,
  input logic [1:0] osc_mode,
  input logic primary_osc_pin,
  output logic ref_clock_pin,
  output logic ref_clock_pin_oe,
  output logic osc_power_down
);
  logic en_r, en_nxt;
  logic rsl_r, rsl_nxt;
  logic src_r, src_nxt;
  logic [3:0] div_r, div_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic osc_prev_r, osc_prev_nxt;
  rco_pkg::rco_state_t state_r, state_nxt;
  logic osc_sync;
  logic osc_rise;
  logic primary_mode;
  logic sleep_ok;
  logic run_req;
  logic div_out;
  logic div_active;
  logic hit_ctrl;
  logic hit_stat;
  logic wr_en;
  logic [31:0] ctrl_word;
  logic [31:0] stat_word;

  // Primary oscillator pin passes two flops before use
  rco_sync u_osc_sync (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .async_in(primary_osc_pin),
    .sync_out(osc_sync)
  );

  // Rising edge of the synchronised oscillator
  assign osc_prev_nxt = osc_sync;
  assign osc_rise = osc_sync & ~osc_prev_r;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      osc_prev_r <= 1'b0;
    end else begin
      osc_prev_r <= osc_prev_nxt;
    end
  end

  // Sleep gating and request to run
  assign primary_mode = (osc_mode != rco_pkg::RCO_OSC_OTHER);
  assign sleep_ok = rsl_r & src_r & primary_mode;
  assign run_req = en_r & (~sleep_mode | sleep_ok);
  assign osc_power_down = sleep_mode & ~src_r;

  rco_div u_div (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .run(run_req),
    .src_osc(src_r),
    .div_sel(div_r),
    .osc_rise(osc_rise),
    .clk_out(div_out),
    .active(div_active)
  );

  // Output pin and its enable
  assign ref_clock_pin = div_out;
  // Drive stays on until the divider has finished its period, so no high half is cut
  assign ref_clock_pin_oe = en_r | div_active;

  // Output state: off, running, or finishing the current period
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      rco_pkg::RCO_OFF: begin
        if (run_req) begin
          state_nxt = rco_pkg::RCO_RUN;
        end
      end
      rco_pkg::RCO_RUN: begin
        if (!run_req) begin
          state_nxt = rco_pkg::RCO_DRAIN;
        end
      end
      rco_pkg::RCO_DRAIN: begin
        if (run_req) begin
          state_nxt = rco_pkg::RCO_RUN;
        end else if (!div_active) begin
          state_nxt = rco_pkg::RCO_OFF;
        end
      end
      default: begin
        state_nxt = rco_pkg::RCO_OFF;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= rco_pkg::RCO_OFF;
    end else begin
      state_r <= state_nxt;
    end
  end

  // APB decode; zero wait states, unmapped addresses report an error
  assign hit_ctrl = (paddr == rco_pkg::RCO_CTRL_OFS);
  assign hit_stat = (paddr == rco_pkg::RCO_STAT_OFS);
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~(hit_ctrl | hit_stat);
  assign wr_en = psel & penable & pwrite & hit_ctrl;

  // Register images for reads; unused bits read as zero
  always_comb begin
    ctrl_word = 32'h0000_0000;
    ctrl_word[rco_pkg::RCO_EN_BIT] = en_r;
    ctrl_word[rco_pkg::RCO_SLP_BIT] = rsl_r;
    ctrl_word[rco_pkg::RCO_SRC_BIT] = src_r;
    ctrl_word[rco_pkg::RCO_DIV_MSB:rco_pkg::RCO_DIV_LSB] = div_r;
    stat_word = 32'h0000_0000;
    stat_word[rco_pkg::RCO_ST_RUN_BIT] = (state_r == rco_pkg::RCO_RUN);
    stat_word[rco_pkg::RCO_ST_PIN_BIT] = div_out;
    stat_word[rco_pkg::RCO_ST_PD_BIT] = osc_power_down;
    stat_word[rco_pkg::RCO_ST_SLP_BIT] = sleep_mode;
    stat_word[rco_pkg::RCO_ST_DRAIN_BIT] = (state_r == rco_pkg::RCO_DRAIN);
  end

  // Control register next values and read data captured in the setup cycle
  always_comb begin
    en_nxt = en_r;
    rsl_nxt = rsl_r;
    src_nxt = src_r;
    div_nxt = div_r;
    rdata_nxt = rdata_r;
    if (wr_en) begin
      en_nxt = pwdata[rco_pkg::RCO_EN_BIT];
      rsl_nxt = pwdata[rco_pkg::RCO_SLP_BIT];
      src_nxt = pwdata[rco_pkg::RCO_SRC_BIT];
      div_nxt = pwdata[rco_pkg::RCO_DIV_MSB:rco_pkg::RCO_DIV_LSB];
    end
    if (psel && !penable && !pwrite) begin
      if (hit_ctrl) begin
        rdata_nxt = ctrl_word;
      end else if (hit_stat) begin
        rdata_nxt = stat_word;
      end else begin
        rdata_nxt = 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      en_r <= rco_pkg::RCO_EN_RST;
      rsl_r <= rco_pkg::RCO_SLP_RST;
      src_r <= rco_pkg::RCO_SRC_RST;
      div_r <= rco_pkg::RCO_DIV_RST;
      rdata_r <= rco_pkg::RCO_RDATA_RST;
    end else begin
      en_r <= en_nxt;
      rsl_r <= rsl_nxt;
      src_r <= src_nxt;
      div_r <= div_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign prdata = rdata_r;

  // Pin stays low while the output is off
  property p_pin_off;
    @(posedge ref_clk) disable iff (!rst_b)
      (state_r == rco_pkg::RCO_OFF) |-> !ref_clock_pin;
  endproperty
  a_pin_off: assert property (p_pin_off) else $error("pin active while off");

  // Enabling outside Sleep starts the output next cycle
  property p_enable_run;
    @(posedge ref_clk) disable iff (!rst_b)
      (state_r == rco_pkg::RCO_OFF && en_r && !sleep_mode) |=> (state_r == rco_pkg::RCO_RUN);
  endproperty
  a_enable_run: assert property (p_enable_run) else $error("output did not start");

  // A write lands in the divider field one cycle later
  property p_div_write;
    @(posedge ref_clk) disable iff (!rst_b)
      wr_en |=> (div_r == $past(pwdata[rco_pkg::RCO_DIV_MSB:rco_pkg::RCO_DIV_LSB]));
  endproperty
  a_div_write: assert property (p_div_write) else $error("divider field not written");

  // Sleep without run-in-sleep never keeps running
  property p_sleep_stop;
    @(posedge ref_clk) disable iff (!rst_b)
      (sleep_mode && !rsl_r && state_r == rco_pkg::RCO_RUN) |=> (state_r == rco_pkg::RCO_DRAIN);
  endproperty
  a_sleep_stop: assert property (p_sleep_stop) else $error("output kept running in sleep");

  // Running in Sleep needs both bits set
  property p_sleep_both;
    @(posedge ref_clk) disable iff (!rst_b)
      (sleep_mode && !(rsl_r && src_r)) |=> (state_r != rco_pkg::RCO_RUN) || !$past(sleep_mode);
  endproperty
  a_sleep_both: assert property (p_sleep_both) else $error("sleep output without both bits");

  // Non-primary mode blocks sleep output; oscillator off without source bit
  property p_sleep_mode;
    @(posedge ref_clk) disable iff (!rst_b)
      (sleep_mode && osc_mode == rco_pkg::RCO_OSC_OTHER && state_r != rco_pkg::RCO_RUN)
        |=> (state_r != rco_pkg::RCO_RUN) || !$past(sleep_mode) || (osc_mode != 2'h3);
  endproperty
  a_sleep_mode: assert property (p_sleep_mode) else $error("sleep output in bad mode");

  property p_osc_pd;
    @(posedge ref_clk) disable iff (!rst_b)
      (sleep_mode && !src_r) |-> osc_power_down ##1 (!sleep_mode || src_r || osc_power_down);
  endproperty
  a_osc_pd: assert property (p_osc_pd) else $error("oscillator not powered down");

  // System clock source, ratio code 0: a high half lasts one cycle
  property p_sys_track;
    @(posedge ref_clk) disable iff (!rst_b)
      ($rose(ref_clock_pin) && !$past(src_r) && $past(div_r) == 4'h0) |=> !ref_clock_pin;
  endproperty
  a_sys_track: assert property (p_sys_track) else $error("system clock ratio wrong");

  // Ratio code 1 on the system clock: high half is exactly two cycles
  property p_no_runt;
    @(posedge ref_clk) disable iff (!rst_b)
      ($rose(ref_clock_pin) && !$past(src_r) && $past(div_r) == 4'h1)
        |-> ref_clock_pin[*2] ##1 !ref_clock_pin;
  endproperty
  a_no_runt: assert property (p_no_runt) else $error("runt high pulse");

  // Pin never high while its driver is off, so the line sees no cut half
  property p_pin_driven;
    @(posedge ref_clk) disable iff (!rst_b)
      ref_clock_pin |-> ref_clock_pin_oe;
  endproperty
  a_pin_driven: assert property (p_pin_driven) else $error("pin high without drive");

  // Clearing the enable bit ends the running state at once
  property p_disable_stop;
    @(posedge ref_clk) disable iff (!rst_b)
      (!en_r && state_r == rco_pkg::RCO_RUN) |=> (state_r == rco_pkg::RCO_DRAIN);
  endproperty
  a_disable_stop: assert property (p_disable_stop) else $error("running after disable");

  // Both bits set in a primary mode keep the output running in Sleep
  property p_sleep_keep;
    @(posedge ref_clk) disable iff (!rst_b)
      (sleep_mode && en_r && rsl_r && src_r && primary_mode && state_r == rco_pkg::RCO_RUN)
        |=> (state_r == rco_pkg::RCO_RUN);
  endproperty
  a_sleep_keep: assert property (p_sleep_keep) else $error("sleep output stopped");

  // Draining ends once the divider has finished its low half
  property p_drain_end;
    @(posedge ref_clk) disable iff (!rst_b)
      (state_r == rco_pkg::RCO_DRAIN && !div_active && !run_req)
        |=> (state_r == rco_pkg::RCO_OFF);
  endproperty
  a_drain_end: assert property (p_drain_end) else $error("drain did not end");

  // Control bits change only on a write
  property p_ctrl_hold;
    @(posedge ref_clk) disable iff (!rst_b)
      !wr_en |=> ($stable(en_r) && $stable(div_r) && $stable(src_r) && $stable(rsl_r));
  endproperty
  a_ctrl_hold: assert property (p_ctrl_hold) else $error("control changed without write");

  // Control read returns the stored enable bit and divider field
  property p_read_ctrl;
    @(posedge ref_clk) disable iff (!rst_b)
      (psel && !penable && !pwrite && hit_ctrl)
        |=> (prdata[rco_pkg::RCO_EN_BIT] == $past(en_r))
          && (prdata[rco_pkg::RCO_DIV_MSB:rco_pkg::RCO_DIV_LSB] == $past(div_r));
  endproperty
  a_read_ctrl: assert property (p_read_ctrl) else $error("control read mismatch");

  c_run: cover property (@(posedge ref_clk) disable iff (!rst_b)
    state_r == rco_pkg::RCO_RUN ##1 $rose(ref_clock_pin));
  c_drain: cover property (@(posedge ref_clk) disable iff (!rst_b)
    state_r == rco_pkg::RCO_DRAIN ##1 state_r == rco_pkg::RCO_OFF);
  c_sleep_run: cover property (@(posedge ref_clk) disable iff (!rst_b)
    sleep_mode && state_r == rco_pkg::RCO_RUN && src_r);
  c_sleep_drain: cover property (@(posedge ref_clk) disable iff (!rst_b)
    sleep_mode && state_r == rco_pkg::RCO_DRAIN);
endmodule : rco_top

/* rco_pkg.sv */
// Constants and types shared by the reference clock output block.
// Assumes a single 20 MHz bus clock and APB register access.
package rco_pkg;
  // Register byte offsets
  localparam logic [7:0] RCO_CTRL_OFS = 8'h00;
  localparam logic [7:0] RCO_STAT_OFS = 8'h04;
  // Control register field positions
  localparam int RCO_EN_BIT = 15;
  localparam int RCO_SLP_BIT = 13;
  localparam int RCO_SRC_BIT = 12;
  localparam int RCO_DIV_LSB = 8;
  localparam int RCO_DIV_MSB = 11;
  // Status register field positions
  localparam int RCO_ST_RUN_BIT = 0;
  localparam int RCO_ST_PIN_BIT = 1;
  localparam int RCO_ST_PD_BIT = 2;
  localparam int RCO_ST_SLP_BIT = 3;
  localparam int RCO_ST_DRAIN_BIT = 4;
  // Values after reset
  localparam logic RCO_EN_RST = 1'b0;
  localparam logic RCO_SLP_RST = 1'b0;
  localparam logic RCO_SRC_RST = 1'b0;
  localparam logic [3:0] RCO_DIV_RST = 4'h0;
  localparam logic [31:0] RCO_RDATA_RST = 32'h0000_0000;
  // Divider counter width: half period up to 2^15 source edges
  localparam int RCO_CNT_W = 15;
  localparam logic [RCO_CNT_W-1:0] RCO_CNT_RST = 15'h0000;
  // Oscillator configuration codes from the clock controller
  typedef enum logic [1:0] {
    RCO_OSC_EXT = 2'h0,
    RCO_OSC_HSXT = 2'h1,
    RCO_OSC_XT = 2'h2,
    RCO_OSC_OTHER = 2'h3
  } rco_osc_mode_t;
  // Output control states
  typedef enum logic [2:0] {
    RCO_OFF = 3'h1,
    RCO_RUN = 3'h2,
    RCO_DRAIN = 3'h4
  } rco_state_t;
endpackage : rco_pkg

/* rco_sync.sv */
// Two-flop synchroniser for a level arriving from outside the clock domain.
// Assumes the input may change at any time relative to ref_clk.
`timescale 1ns/1ps
module rco_sync (
  input logic ref_clk,
  input logic rst_b,
  input logic async_in,
  output logic sync_out
);
  logic meta_r;
  logic sync_r;

  // First flop feeds only the second one
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
    end else begin
      meta_r <= async_in;
      sync_r <= meta_r;
    end
  end

  assign sync_out = sync_r;
endmodule : rco_sync

/* rco_div.sv */
// Glitch-free divider for the reference clock output.
// Assumes osc_rise is a one-cycle pulse per primary oscillator rising edge.
`timescale 1ns/1ps
module rco_div (
  input logic ref_clk,
  input logic rst_b,
  input logic run,
  input logic src_osc,
  input logic [3:0] div_sel,
  input logic osc_rise,
  output logic clk_out,
  output logic active
);
  logic active_r, active_nxt;
  logic out_r, out_nxt;
  logic src_r, src_nxt;
  logic [3:0] div_r, div_nxt;
  logic [rco_pkg::RCO_CNT_W-1:0] cnt_r, cnt_nxt;
  logic [rco_pkg::RCO_CNT_W-1:0] limit;
  logic tick;

  // Each half period lasts 2^div source edges
  assign limit = rco_pkg::RCO_CNT_W'((16'h0001 << div_r) - 16'h0001);
  // System clock source counts every bus clock edge, so it follows any clock switch
  assign tick = src_r ? osc_rise : 1'b1;

  // Settings are taken only on leaving idle or at the end of a full low half, so no runt pulses
  always_comb begin
    active_nxt = active_r;
    out_nxt = out_r;
    src_nxt = src_r;
    div_nxt = div_r;
    cnt_nxt = cnt_r;
    if (!active_r) begin
      out_nxt = 1'b0;
      cnt_nxt = rco_pkg::RCO_CNT_RST;
      if (run) begin
        active_nxt = 1'b1;
        src_nxt = src_osc;
        div_nxt = div_sel;
      end
    end else if (tick) begin
      if (cnt_r == limit) begin
        cnt_nxt = rco_pkg::RCO_CNT_RST;
        if (out_r) begin
          out_nxt = 1'b0;
        end else if (run) begin
          out_nxt = 1'b1;
          src_nxt = src_osc;
          div_nxt = div_sel;
        end else begin
          active_nxt = 1'b0;
        end
      end else begin
        cnt_nxt = cnt_r + 1'b1;
      end
    end
  end

  // Divider state registers
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      active_r <= 1'b0;
      out_r <= 1'b0;
      src_r <= rco_pkg::RCO_SRC_RST;
      div_r <= rco_pkg::RCO_DIV_RST;
      cnt_r <= rco_pkg::RCO_CNT_RST;
    end else begin
      active_r <= active_nxt;
      out_r <= out_nxt;
      src_r <= src_nxt;
      div_r <= div_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  assign clk_out = out_r;
  assign active = active_r;
endmodule : rco_div

/* rco_clk_sink.sv */
// Partner model: an external device clocked from the reference output pin.
// Assumes the pin has a pull-down, so an undriven line reads low.
`timescale 1ns/1ps
module rco_clk_sink (
  input logic ref_clk,
  input logic rst_b,
  input logic ref_clock_pin,
  input logic ref_clock_pin_oe,
  input logic clr_min,
  output logic [31:0] edge_cnt,
  output logic [31:0] hi_len,
  output logic [31:0] lo_len,
  output logic [31:0] min_len
);
  logic wire_lvl;
  logic last_r;
  logic [31:0] run_r;
  // Line level seen by the device; the pull-down wins when undriven
  assign wire_lvl = ref_clock_pin_oe & ref_clock_pin;
  // Measure every half period in bus clock cycles
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      last_r <= 1'b0;
      run_r <= 32'h0000_0000;
      edge_cnt <= 32'h0000_0000;
      hi_len <= 32'h0000_0000;
      lo_len <= 32'h0000_0000;
      min_len <= 32'hFFFF_FFFF;
    end else begin
      if (clr_min)
        min_len <= 32'hFFFF_FFFF;
      if (wire_lvl !== last_r) begin
        edge_cnt <= edge_cnt + 32'h1;
        if (last_r)
          hi_len <= run_r;
        else
          lo_len <= run_r;
        if (!clr_min && run_r < min_len)
          min_len <= run_r;
        run_r <= 32'h0000_0001;
        last_r <= wire_lvl;
      end else begin
        run_r <= run_r + 32'h1;
      end
    end
  end
endmodule : rco_clk_sink

/* reference_clock_output_bench.sv */
// Self-checking bench for the reference clock output block.
// Assumes zero-wait APB and a primary oscillator well below 10 MHz.
`timescale 1ns/1ps
module reference_clock_output_bench;
  logic ref_clk, rst_b, psel, penable, pwrite, sleep_mode, primary_osc_pin, clr_min;
  logic pready, pslverr, ref_clock_pin, ref_clock_pin_oe, osc_power_down, err;
  logic [1:0] osc_mode;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd, c, edge_cnt, hi_len, lo_len, min_len;
  int err_count = 0;
  int num_checks = 0;
  int cyc = 0;
  // Divider rows: control word and expected half period in bus cycles
  logic [15:0] row_ctrl [6] = '{16'h8000, 16'h8100, 16'h8200, 16'h8300, 16'h9000, 16'h9100};
  logic [31:0] row_half [6] = '{32'h1, 32'h2, 32'h4, 32'h8, 32'h5, 32'hA};
  // Sleep rows: control word and {osc mode, runs in sleep, osc powered down}
  logic [15:0] slp_ctrl [6] = '{16'hB000, 16'hB000, 16'hB000, 16'hB000, 16'h9000, 16'hA000};
  logic [3:0] slp_exp [6] = '{4'h2, 4'h6, 4'hA, 4'hC, 4'h0, 4'h1};

  rco_top dut (.ref_clk(ref_clk), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sleep_mode(sleep_mode), .osc_mode(osc_mode),
    .primary_osc_pin(primary_osc_pin), .ref_clock_pin(ref_clock_pin),
    .ref_clock_pin_oe(ref_clock_pin_oe), .osc_power_down(osc_power_down));
  rco_clk_sink sink (.ref_clk(ref_clk), .rst_b(rst_b), .ref_clock_pin(ref_clock_pin),
    .ref_clock_pin_oe(ref_clock_pin_oe), .clr_min(clr_min), .edge_cnt(edge_cnt),
    .hi_len(hi_len), .lo_len(lo_len), .min_len(min_len));

  // Bus clock, 50 ns period
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  // Primary oscillator at 4 MHz, phase unrelated to the bus clock
  initial begin
    primary_osc_pin = 1'b0;
    #13;
    forever #125 primary_osc_pin = ~primary_osc_pin;
  end
  // Hang guard
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      wrap_up();
    end
  end

  task chk_word(input logic [31:0] got, input logic [31:0] exp, input string msg);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: %s got %h want %h", $time, msg, got, exp);
    end
  endtask : chk_word

  task chk_bit(input logic got, input logic exp, input string msg);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: %s got %b want %b", $time, msg, got, exp);
    end
  endtask : chk_bit

  // One APB transfer; read data and error taken at the completing edge
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task wait_edges(input int n);
    logic [31:0] e;
    e = edge_cnt + 32'(n);
    while (edge_cnt < e) @(posedge ref_clk);
  endtask : wait_edges

  task wrap_up;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : wrap_up

  // Main sequence
  initial begin
    rst_b = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    sleep_mode = 1'b0;
    osc_mode = 2'h0;
    clr_min = 1'b0;
    repeat (10) @(posedge ref_clk);
    rst_b <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      clr_min <= 1'b1;
      @(posedge ref_clk);
      clr_min <= 1'b0;
      apb(1'b1, 8'h00, {16'h0000, row_ctrl[i]});
      wait_edges(6);
      chk_word(hi_len, row_half[i], "high half");
      chk_word(lo_len, row_half[i], "low half");
      chk_bit(ref_clock_pin_oe, 1'b1, "drive enable");
      if (i > 0 && i < 4)
        chk_word(min_len, row_half[i-1], "shortest half");
      apb(1'b0, 8'h04, 32'h0);
      chk_bit(rd[0], 1'b1, "running flag");
    end
    for (int i = 0; i < 6; i++) begin
      sleep_mode <= 1'b0;
      osc_mode <= slp_exp[i][3:2];
      apb(1'b1, 8'h00, {16'h0000, slp_ctrl[i]});
      wait_edges(4);
      sleep_mode <= 1'b1;
      repeat (40) @(posedge ref_clk);
      c = edge_cnt;
      repeat (40) @(posedge ref_clk);
      chk_bit(edge_cnt != c, slp_exp[i][1], "runs in sleep");
      chk_bit(osc_power_down, slp_exp[i][0], "osc power down");
      if (!slp_exp[i][1])
        chk_bit(ref_clock_pin, 1'b0, "stopped low");
      apb(1'b0, 8'h04, 32'h0);
      chk_bit(rd[rco_pkg::RCO_ST_PD_BIT], slp_exp[i][0], "status power down");
      chk_bit(rd[rco_pkg::RCO_ST_SLP_BIT], 1'b1, "status sleep");
    end
    sleep_mode <= 1'b0;
    // Only the documented control bits are kept; enable clear leaves pin idle
    apb(1'b1, 8'h00, 32'hFFFF_7FFF);
    apb(1'b0, 8'h00, 32'h0);
    chk_word(rd, 32'h0000_3F00, "control readback");
    repeat (20) @(posedge ref_clk);
    chk_bit(ref_clock_pin_oe, 1'b0, "drive off");
    // Status is read only; unmapped address errors and changes nothing
    apb(1'b1, 8'h04, 32'hFFFF_FFFF);
    chk_bit(err, 1'b0, "status write error");
    apb(1'b1, 8'h08, 32'h0);
    chk_bit(err, 1'b1, "unmapped write error");
    apb(1'b0, 8'h08, 32'h0);
    chk_word({rd[31:1], err}, 32'h1, "unmapped read");
    apb(1'b0, 8'h00, 32'h0);
    chk_word(rd, 32'h0000_3F00, "control kept");
    chk_bit(pready, 1'b1, "ready");
    // Disable in mid-period finishes low
    apb(1'b1, 8'h00, 32'h0000_8200);
    wait_edges(3);
    clr_min <= 1'b1;
    @(posedge ref_clk);
    clr_min <= 1'b0;
    apb(1'b1, 8'h00, 32'h0);
    repeat (20) @(posedge ref_clk);
    chk_bit(ref_clock_pin, 1'b0, "pin after disable");
    chk_bit(min_len >= 32'h4, 1'b1, "no cut half on disable");
    apb(1'b0, 8'h04, 32'h0);
    chk_bit(rd[0], 1'b0, "stopped flag");
    // Reset in mid-run clears control and output
    apb(1'b1, 8'h00, 32'h0000_8000);
    wait_edges(2);
    rst_b <= 1'b0;
    repeat (2) @(posedge ref_clk);
    chk_bit(ref_clock_pin | ref_clock_pin_oe, 1'b0, "pin in reset");
    rst_b <= 1'b1;
    apb(1'b0, 8'h00, 32'h0);
    chk_word(rd, 32'h0, "control after reset");
    wrap_up();
  end
endmodule : reference_clock_output_bench
